// ==== hdl/hips_regs.svh ====
// constants of the insertion power sequencer: timing and register map
`ifndef HIPS_REGS_SVH
`define HIPS_REGS_SVH
`define HIPS_CLK_MHZ 250
`define HIPS_INS_MS 20
`define HIPS_POR_MS 20
`define HIPS_REL_MS 200
`define HIPS_OC_US 20
`define HIPS_LO_US 32
`define HIPS_INS_CYC (`HIPS_INS_MS * 1000 * `HIPS_CLK_MHZ)
`define HIPS_POR_CYC (`HIPS_POR_MS * 1000 * `HIPS_CLK_MHZ)
`define HIPS_REL_CYC (`HIPS_REL_MS * 1000 * `HIPS_CLK_MHZ)
`define HIPS_OC_CYC (`HIPS_OC_US * `HIPS_CLK_MHZ)
`define HIPS_LO_CYC (`HIPS_LO_US * `HIPS_CLK_MHZ)
`define HIPS_CTRL_OFS 8'h00
`define HIPS_STAT_OFS 8'h04
`define HIPS_CTRL_EN_BIT 0
`define HIPS_CTRL_RST 32'h0000_0001
`define HIPS_ST_PUMP_BIT 0
`define HIPS_ST_TRIP_BIT 1
`define HIPS_ST_PG_BIT 2
`define HIPS_ST_RST_BIT 3
`define HIPS_ST_INS_BIT 4
`define HIPS_ST_FSM_LSB 5
`endif

// ==== hdl/hips_pkg.sv ====
// types of the insertion power sequencer
package hips_pkg;
  typedef enum logic [1:0] {
    HIPS_THR_FLOAT,
    HIPS_THR_LOWOUT,
    HIPS_THR_GND
  } hips_thr_t;
  typedef enum logic [2:0] {
    HIPS_OFF,
    HIPS_ON,
    HIPS_HARD,
    HIPS_DRAIN
  } hips_state_t;
endpackage : hips_pkg

// ==== hdl/hips_seq.sv ====
// insertion power sequencer: debounce, breaker, supervisor, ahb-lite regs
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/10ps
`include "hips_regs.svh"
module hips_seq #(
  parameter int unsigned INS_CYC = `HIPS_INS_CYC,
  parameter int unsigned POR_CYC = `HIPS_POR_CYC,
  parameter int unsigned REL_CYC = `HIPS_REL_CYC,
  parameter int unsigned OC_CYC = `HIPS_OC_CYC,
  parameter int unsigned LO_CYC = `HIPS_LO_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic conn_sense_a_n,
  input wire logic conn_sense_b_n,
  input wire logic hard_reset_n,
  input wire logic low_supply_lockout,
  input wire logic high_supply_lockout,
  input wire hips_pkg::hips_thr_t threshold_select,
  input wire logic low_rail_above_4v65,
  input wire logic low_rail_above_2v90,
  input wire logic low_rail_above_5v88,
  input wire logic outputs_below_trip,
  input wire logic overcurrent_sense_high_rail,
  input wire logic overcurrent_sense_low_rail,
  output logic pump_on,
  output logic gate_drive_high_rail,
  output logic gate_drive_low_rail,
  output logic gate_pull_low,
  output logic overcurrent_flag_n,
  output logic supply_good,
  output logic bus_disable,
  output logic sys_reset_n
);
  localparam int CW = 26;
  typedef logic [CW-1:0] hips_cnt_t;
  localparam hips_cnt_t INS_L = CW'(INS_CYC);
  localparam hips_cnt_t POR_L = CW'(POR_CYC);
  localparam hips_cnt_t REL_L = CW'(REL_CYC);
  localparam hips_cnt_t OC_L = CW'(OC_CYC);
  localparam hips_cnt_t LO_L = CW'(LO_CYC);
  localparam logic [31:0] CTRL_RST = `HIPS_CTRL_RST;

  // saturating interval counter, cleared whenever its condition breaks
  function automatic hips_cnt_t sat_cnt(input logic run, input hips_cnt_t c,
                                        input hips_cnt_t lim);
    hips_cnt_t r;
    r = '0;
    if (run) begin
      r = (c == lim) ? c : c + hips_cnt_t'(1);
    end
    return r;
  endfunction : sat_cnt

  //////////////////////////////////////////////////////////////////////////
  hips_pkg::hips_state_t state_q, state_d;
  hips_cnt_t ins_cnt_q, por_cnt_q, rel_cnt_q, oc_cnt_q, lo_cnt_q;
  logic trip_q, rst_q, pump_q, en_q;
  logic a_sel_q, a_wr_q;
  logic [7:0] a_ofs_q;
  logic [31:0] rdata_q;

  wire conn_open = conn_sense_a_n | conn_sense_b_n;
  // either supply under lockout holds everything off
  wire lockout = low_supply_lockout | high_supply_lockout;
  wire oc_any = overcurrent_sense_high_rail | overcurrent_sense_low_rail;
  wire ins_ok = ins_cnt_q == INS_L;
  wire por_hit = !hard_reset_n && por_cnt_q == POR_L;
  // only an indication longer than the window trips
  wire oc_hit = oc_any && oc_cnt_q == OC_L;
  wire thr_above =
    (threshold_select == hips_pkg::HIPS_THR_GND) ? low_rail_above_5v88 :
    (threshold_select == hips_pkg::HIPS_THR_LOWOUT) ? low_rail_above_2v90 :
    low_rail_above_4v65;
  // causes that assert reset without waiting
  wire force_rst = conn_open | !hard_reset_n | lockout;
  wire lo_done = !supply_good && lo_cnt_q == LO_L;
  wire rel_done = rel_cnt_q == REL_L;
  wire pumps_ok = !trip_q && !lockout && !conn_open && en_q;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    case (state_q)
      hips_pkg::HIPS_OFF: begin
        // start refused while the hard-reset input is low
        if (por_hit) begin
          state_d = hips_pkg::HIPS_HARD;
        end else if (pumps_ok && ins_ok && hard_reset_n) begin
          state_d = hips_pkg::HIPS_ON;
        end
      end
      hips_pkg::HIPS_ON: begin
        // sense high drops pumps on the next edge
        if (por_hit) begin
          state_d = hips_pkg::HIPS_HARD;
        end else if (!pumps_ok || oc_hit) begin
          state_d = hips_pkg::HIPS_OFF;
        end
      end
      hips_pkg::HIPS_HARD: begin
        if (hard_reset_n) begin
          state_d = hips_pkg::HIPS_DRAIN;
        end
      end
      hips_pkg::HIPS_DRAIN: begin
        // wait for rails to discharge before power-up
        if (!hard_reset_n) begin
          state_d = hips_pkg::HIPS_HARD;
        end else if (outputs_below_trip) begin
          state_d = hips_pkg::HIPS_OFF;
        end
      end
      default: state_d = hips_pkg::HIPS_OFF;
    endcase
  end

  // all timers on hclk, cleared when condition breaks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ins_cnt_q <= '0;
      por_cnt_q <= '0;
      oc_cnt_q <= '0;
      lo_cnt_q <= '0;
      rel_cnt_q <= '0;
    end else begin
      ins_cnt_q <= sat_cnt(!conn_open, ins_cnt_q, INS_L);
      por_cnt_q <= sat_cnt(!hard_reset_n, por_cnt_q, POR_L);
      oc_cnt_q <= sat_cnt(oc_any, oc_cnt_q, OC_L);
      lo_cnt_q <= sat_cnt(!supply_good, lo_cnt_q, LO_L);
      // release timer restarts on any drop
      rel_cnt_q <= sat_cnt(supply_good && !force_rst, rel_cnt_q, REL_L);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= hips_pkg::HIPS_OFF;
      pump_q <= 1'b0;
      trip_q <= 1'b0;
      rst_q <= 1'b1;
    end else begin
      state_q <= state_d;
      pump_q <= state_d == hips_pkg::HIPS_ON;
      // hard reset clears, a new trip wins
      if (oc_hit) begin
        trip_q <= 1'b1;
      end else if (!hard_reset_n) begin
        trip_q <= 1'b0;
      end
      // supply-good loss resets only after a full 32 us low; force_rst resets at once
      // release after full 200 ms high
      if (force_rst || lo_done) begin
        rst_q <= 1'b1;
      end else if (rel_done) begin
        rst_q <= 1'b0;
      end
    end
  end

  assign pump_on = pump_q;
  // gates follow pumps, else pulled to ground
  assign gate_drive_high_rail = pump_q;
  assign gate_drive_low_rail = pump_q;
  assign gate_pull_low = !pump_q;
  assign overcurrent_flag_n = !trip_q;
  // comparator path, no delay; trip drops it with the flag
  assign supply_good = thr_above && !trip_q;
  assign sys_reset_n = !rst_q;
  // buffers off while board is held in reset
  assign bus_disable = rst_q;

  //////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always okay
  wire a_take = hsel && hready && htrans[1];
  wire [31:0] ctrl_rd = {31'h0, en_q};
  wire [31:0] stat_rd = {24'h0, 3'(state_q), ins_ok, rst_q, supply_good,
                         trip_q, pump_q};
  wire [31:0] rd_mux =
    (haddr[7:0] == `HIPS_CTRL_OFS) ? ctrl_rd :
    (haddr[7:0] == `HIPS_STAT_OFS) ? stat_rd : 32'h0;
  wire in_map = haddr[31:8] == 24'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_sel_q <= 1'b0;
      a_wr_q <= 1'b0;
      a_ofs_q <= 8'h00;
      rdata_q <= 32'h0;
      en_q <= CTRL_RST[`HIPS_CTRL_EN_BIT];
    end else begin
      // unmapped addresses alias the low byte, so they must not write
      a_sel_q <= a_take && in_map;
      a_wr_q <= hwrite;
      a_ofs_q <= haddr[7:0];
      rdata_q <= (a_take && !hwrite && in_map) ? rd_mux : 32'h0;
      if (a_sel_q && a_wr_q && a_ofs_q == `HIPS_CTRL_OFS) begin
        en_q <= hwdata[`HIPS_CTRL_EN_BIT];
      end
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  //////////////////////////////////////////////////////////////////////////
  a_ins_first: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(pump_on) |-> $past(ins_ok) && $past(hard_reset_n))
    else $error("pumps started before insertion debounce");
  a_rst_causes: assert property (
    @(posedge hclk) disable iff (!hresetn)
    force_rst |=> !sys_reset_n)
    else $error("reset not asserted for immediate cause");
  a_hard_off: assert property (@(posedge hclk) disable iff (!hresetn)
    por_hit |=> !pump_on ##1 !pump_on)
    else $error("pumps on after hard reset");
  a_drain_wait: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_q == hips_pkg::HIPS_DRAIN && !outputs_below_trip |=> !pump_on)
    else $error("power-up before rails drained");
  a_trip_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !hard_reset_n && !oc_hit |=> overcurrent_flag_n)
    else $error("breaker not cleared by hard reset");
  a_trip_when: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(overcurrent_flag_n) |-> $past(oc_any) && $past(oc_cnt_q) == OC_L)
    else $error("breaker tripped early");
  a_trip_gates: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !overcurrent_flag_n |-> !gate_drive_high_rail && gate_pull_low)
    else $error("gates driven while tripped");
  a_trip_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !overcurrent_flag_n && hard_reset_n |=> !overcurrent_flag_n)
    else $error("breaker released without hard reset");
  a_rel_after: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(sys_reset_n) |-> $past(rel_cnt_q) == REL_L && $past(supply_good))
    else $error("reset released too early");
  a_pg_low_rst: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !force_rst && lo_done |=> !sys_reset_n)
    else $error("reset missing after supply-good loss");
  a_conn_drop: assert property (
    @(posedge hclk) disable iff (!hresetn)
    conn_open |=> !pump_on)
    else $error("pumps on with sense input high");
  a_lockout: assert property (@(posedge hclk) disable iff (!hresetn)
    lockout |=> !pump_on && !sys_reset_n && bus_disable)
    else $error("lockout not honoured");
  a_pump_state: assert property (
    @(posedge hclk) disable iff (!hresetn)
    pump_on == (state_q == hips_pkg::HIPS_ON))
    else $error("pump-on differs from state");
  // gates and pull-down follow the pumps
  a_gate_follow: assert property (
    @(posedge hclk) disable iff (!hresetn)
    gate_drive_high_rail == pump_on && gate_drive_low_rail == pump_on &&
    gate_pull_low == !pump_on)
    else $error("gate drives disagree with pumps");
  // floating select uses the middle threshold
  a_thr_float: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !trip_q && threshold_select == hips_pkg::HIPS_THR_FLOAT
    |-> supply_good == low_rail_above_4v65)
    else $error("floating threshold not selected");
  // tie to the low output selects the low threshold
  a_thr_lowout: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !trip_q && threshold_select == hips_pkg::HIPS_THR_LOWOUT
    |-> supply_good == low_rail_above_2v90)
    else $error("low-output threshold not selected");
  // grounded select uses the high threshold
  a_thr_gnd: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !trip_q && threshold_select == hips_pkg::HIPS_THR_GND
    |-> supply_good == low_rail_above_5v88)
    else $error("grounded threshold not selected");
  a_trip_pg: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !overcurrent_flag_n |-> !supply_good)
    else $error("supply-good high while tripped");
  // reset follows the trip once the low window ends
  a_trip_late: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !overcurrent_flag_n && lo_cnt_q == LO_L |=> !sys_reset_n)
    else $error("reset missing after trip");
  // release timer restarts on any drop
  a_rel_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !supply_good |=> rel_cnt_q == '0)
    else $error("release timer kept running");
  a_dip_keep: assert property (
    @(posedge hclk) disable iff (!hresetn)
    sys_reset_n && !force_rst && !lo_done |=> sys_reset_n)
    else $error("reset asserted on short dip");
  // no power-up from the hard-reset state
  a_hard_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_q == hips_pkg::HIPS_HARD |=> !pump_on)
    else $error("pumps on during hard reset");
  // long hard-reset low enters the hard state
  a_por_enter: assert property (
    @(posedge hclk) disable iff (!hresetn)
    por_hit |=> state_q == hips_pkg::HIPS_HARD)
    else $error("hard reset not entered");
  a_drain_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_q == hips_pkg::HIPS_DRAIN && hard_reset_n && !outputs_below_trip
    |=> state_q == hips_pkg::HIPS_DRAIN)
    else $error("drain left with charged rails");
  // a trip drops the flag on the next edge
  a_trip_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    oc_hit |=> !overcurrent_flag_n)
    else $error("flag not lowered on trip");
  // tripped breaker keeps the pumps off
  a_trip_pumps: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !overcurrent_flag_n |-> !pump_on)
    else $error("pumps on while tripped");
  a_bus_follow: assert property (
    @(posedge hclk) disable iff (!hresetn)
    bus_disable == !sys_reset_n)
    else $error("bus-disable differs from reset");
  // overcurrent window restarts when the indication stops
  a_oc_restart: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !oc_any |=> oc_cnt_q == '0)
    else $error("overcurrent timer not restarted");
  // no start before the insertion debounce
  a_ins_wait: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !ins_ok && !pump_on |=> !pump_on)
    else $error("pumps started before debounce");
endmodule : hips_seq

// ==== test/hips_board_model.sv ====
// backplane connector and board rail model facing the sequencer
`timescale 1ns/10ps
module hips_board_model #(
  parameter int RAMP = 40
) (
  input wire logic hclk,
  input wire logic seat_a,
  input wire logic seat_b,
  input wire logic [1:0] target,
  input wire logic dip,
  input wire logic stuck,
  input wire logic pump_on,
  output logic conn_sense_a_n,
  output logic conn_sense_b_n,
  output logic low_rail_above_2v90,
  output logic low_rail_above_4v65,
  output logic low_rail_above_5v88,
  output logic outputs_below_trip
);
  int cnt = 0;
  logic [1:0] lvl;
  ////////////////////////////////////////////////////////////////////////////
  // grounded sense pins
  assign conn_sense_a_n = !seat_a;
  assign conn_sense_b_n = !seat_b;
  // slow ramp and drain, so a hard reset can see charged outputs
  always @(posedge hclk) begin
    if (pump_on && cnt < RAMP)
      cnt <= cnt + 1;
    else if (!pump_on && cnt > 0)
      cnt <= cnt - 1;
  end
  assign lvl = (cnt == RAMP && !dip) ? target : 2'h0;
  assign low_rail_above_2v90 = lvl >= 2'h1;
  assign low_rail_above_4v65 = lvl >= 2'h2;
  assign low_rail_above_5v88 = lvl == 2'h3;
  // stuck stands for a load that holds the rails up after pumps stop
  assign outputs_below_trip = cnt == 0 && !stuck;
endmodule : hips_board_model

// ==== test/hot_insertion_power_sequencer_tb.sv ====
// self-checking bench for the insertion power sequencer
`timescale 1ns/10ps
`include "hips_regs.svh"
module hot_insertion_power_sequencer_tb;
  localparam int INS = 20, POR = 20, REL = 50, OC = 5, LO = 8, RAMP = 40;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, dip = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, target = 2'h2;
  logic [2:0] hsize = 3'h2;
  logic seat_a = 1'h0, seat_b = 1'h0, hr_n = 1'h1, stuck = 1'h0;
  logic lo_lk = 1'h0, hi_lk = 1'h0, oc_h = 1'h0, oc_l = 1'h0, e;
  hips_pkg::hips_thr_t thr = hips_pkg::HIPS_THR_FLOAT;
  logic hready, hresp, sa_n, sb_n, a29, a46, a58, below, pump_on, g_hi;
  logic g_lo, pull, flag_n, pg, bus_dis, rst_n;
  int num_errors = 0, samples_checked = 0;
  always #2 hclk = ~hclk;
  hips_board_model #(.RAMP(RAMP)) board (.hclk(hclk), .seat_a(seat_a),
    .seat_b(seat_b), .target(target), .dip(dip), .stuck(stuck),
    .pump_on(pump_on), .conn_sense_a_n(sa_n), .conn_sense_b_n(sb_n),
    .low_rail_above_2v90(a29), .low_rail_above_4v65(a46),
    .low_rail_above_5v88(a58), .outputs_below_trip(below));
  hips_seq #(.INS_CYC(INS), .POR_CYC(POR), .REL_CYC(REL), .OC_CYC(OC),
    .LO_CYC(LO)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .conn_sense_a_n(sa_n), .conn_sense_b_n(sb_n),
    .hard_reset_n(hr_n), .low_supply_lockout(lo_lk),
    .high_supply_lockout(hi_lk), .threshold_select(thr),
    .low_rail_above_4v65(a46), .low_rail_above_2v90(a29),
    .low_rail_above_5v88(a58), .outputs_below_trip(below),
    .overcurrent_sense_high_rail(oc_h), .overcurrent_sense_low_rail(oc_l),
    .pump_on(pump_on), .gate_drive_high_rail(g_hi),
    .gate_drive_low_rail(g_lo), .gate_pull_low(pull),
    .overcurrent_flag_n(flag_n), .supply_good(pg), .bus_disable(bus_dis),
    .sys_reset_n(rst_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge hclk);
  endtask : step
  task automatic mid;
    @(negedge hclk);
  endtask : mid
  // bounded wait; running out ends the run
  task automatic wt(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge hclk);
      n++;
    end
    chk(s, v);
    if (s !== v)
      tally_and_finish;
  endtask : wt
  task automatic hrdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'h1 && n < 20);
    if (hready !== 1'h1) begin
      num_errors++;
      tally_and_finish;
    end
  endtask : hrdy
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hrdy;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    hrdy;
    r = hrdata;
  endtask : ahb
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    step(8);
    mid;
    chk(pump_on, 1'h0);
    chk(pull, 1'h1);
    chk({rst_n, bus_dis, flag_n}, 3'h3);
    step(8);
    hresetn <= 1'h1;
    ahb(1'h0, `HIPS_CTRL_OFS, 32'h0, rd);
    chk(rd, `HIPS_CTRL_RST);
    ahb(1'h1, 32'h0000_0100, 32'h0, rd);
    ahb(1'h0, 32'h0000_0100, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'h0, `HIPS_CTRL_OFS, 32'h0, rd);
    chk(rd, `HIPS_CTRL_RST);
    seat_a <= 1'h1;
    seat_b <= 1'h1;
    step(INS);
    mid;
    chk({pump_on, g_hi, g_lo}, 3'h0);
    wt(pump_on, 1'h1, 6);
    chk({g_hi, g_lo, pull}, 3'h6);
    wt(pg, 1'h1, RAMP + 4);
    step(REL - 2);
    mid;
    chk({rst_n, bus_dis}, 2'h1);
    wt(rst_n, 1'h1, 6);
    chk(bus_dis, 1'h0);
    step(1);
    dip <= 1'h1;
    mid;
    chk(pg, 1'h0);
    step(LO - 4);
    dip <= 1'h0;
    step(LO + 4);
    mid;
    chk(rst_n, 1'h1);
    step(1);
    dip <= 1'h1;
    step(LO - 2);
    mid;
    chk(rst_n, 1'h1);
    wt(rst_n, 1'h0, 6);
    step(1);
    dip <= 1'h0;
    step(REL / 2);
    dip <= 1'h1;
    step(2);
    dip <= 1'h0;
    step(REL - 2);
    mid;
    chk(rst_n, 1'h0);
    wt(rst_n, 1'h1, 8);
    step(1);
    oc_h <= 1'h1;
    step(OC - 2);
    oc_h <= 1'h0;
    step(4);
    mid;
    chk(flag_n, 1'h1);
    step(1);
    oc_l <= 1'h1;
    step(OC - 1);
    mid;
    chk(flag_n, 1'h1);
    wt(flag_n, 1'h0, 6);
    chk({pg, pump_on, g_hi, g_lo, pull}, 5'h1);
    step(LO - 2);
    mid;
    chk(rst_n, 1'h1);
    wt(rst_n, 1'h0, 6);
    step(1);
    oc_l <= 1'h0;
    step(20);
    mid;
    chk({flag_n, pump_on}, 2'h0);
    step(1);
    hr_n <= 1'h0;
    step(3);
    mid;
    chk({flag_n, rst_n}, 2'h2);
    step(POR + 2);
    mid;
    chk(pump_on, 1'h0);
    step(RAMP);
    mid;
    chk(pump_on, 1'h0);
    step(1);
    stuck <= 1'h1;
    hr_n <= 1'h1;
    step(10);
    mid;
    chk(pump_on, 1'h0);
    step(1);
    stuck <= 1'h0;
    wt(pump_on, 1'h1, 8);
    wt(pg, 1'h1, RAMP + 4);
    for (int l = 1; l < 4; l++) begin
      for (int s = 0; s < 3; s++) begin
        step(1);
        target <= l[1:0];
        thr <= hips_pkg::hips_thr_t'(s[1:0]);
        e = (s == 0) ? (l >= 2) : (s == 1) ? (l >= 1) : (l == 3);
        mid;
        chk(pg, e);
      end
    end
    ahb(1'h1, `HIPS_CTRL_OFS, 32'h0, rd);
    step(3);
    mid;
    chk(pump_on, 1'h0);
    ahb(1'h0, `HIPS_STAT_OFS, 32'h0, rd);
    chk(rd[`HIPS_ST_PUMP_BIT], 1'h0);
    ahb(1'h1, `HIPS_CTRL_OFS, 32'h1, rd);
    wt(pump_on, 1'h1, 8);
    step(1);
    seat_b <= 1'h0;
    step(1);
    mid;
    chk({pump_on, rst_n}, 2'h0);
    wt(bus_dis, 1'h1, 2);
    step(1);
    seat_b <= 1'h1;
    wt(pump_on, 1'h1, INS + 6);
    step(1);
    lo_lk <= 1'h1;
    step(2);
    mid;
    chk({pump_on, rst_n}, 2'h0);
    step(1);
    lo_lk <= 1'h0;
    hi_lk <= 1'h1;
    step(INS + 8);
    mid;
    chk(pump_on, 1'h0);
    tally_and_finish;
  end
endmodule : hot_insertion_power_sequencer_tb
